// File: include/bdi_pkg.sv
// bdi_pkg: constants and carrier types of the bridge doorbell interrupt block.
// assumes a byte-addressed register port with 32-bit data, one clock, synchronous reset.
package bdi_pkg;

   localparam int unsigned BDI_ADDR_W = 8;
   localparam int unsigned BDI_DATA_W = 32;
   localparam int unsigned BDI_HALF_W = 16;
   localparam int unsigned BDI_SIDES = 2;

   // half-word positions inside each register word
   localparam int unsigned BDI_PRI_LSB = 0;
   localparam int unsigned BDI_SEC_LSB = 16;

   // index of each side in the bank arrays
   localparam int unsigned BDI_SIDE_PRI = 0;
   localparam int unsigned BDI_SIDE_SEC = 1;

   // byte addresses of the register words
   localparam logic [7:0] BDI_OFS_REQ_CLEAR = 8'h70;
   localparam logic [7:0] BDI_OFS_REQ_SET = 8'h74;
   localparam logic [7:0] BDI_OFS_CLEAR_GUARD = 8'h78;
   localparam logic [7:0] BDI_OFS_SET_GUARD = 8'h7c;

   // reset values, per half-word; the idle read word is a full 32 bits
   localparam logic [15:0] BDI_REQ_RST = 16'h0000;
   localparam logic [15:0] BDI_GUARD_RST = 16'hffff;
   localparam logic [31:0] BDI_RDATA_IDLE = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bdi_bus_req_t;

   typedef struct packed {
      logic clr_wr;
      logic set_wr;
      logic cguard_wr;
      logic sguard_wr;
   } bdi_bank_wr_t;

endpackage : bdi_pkg

// File: hdl/bdi_side_bank.sv
// bdi_side_bank: request bits and their two guard masks for one bridge interface.
// assumes write strobes are already decoded and one-hot, one cycle each.
`timescale 1ns/1ps

module bdi_side_bank
   import bdi_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire bdi_pkg::bdi_bank_wr_t wr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] req_o,
   output logic [15:0] clr_guard_o,
   output logic [15:0] set_guard_o
);

   import bdi_pkg::*;

   logic [15:0] req_q;
   logic [15:0] req_d;
   logic [15:0] clr_guard_q;
   logic [15:0] set_guard_q;

   // set and clear share one array; a set is never lost to a clear
   always_comb
   begin
      req_d = req_q;
      if (wr_i.set_wr)
      begin
         req_d = req_q | (wdata_i & ~set_guard_q);
      end
      else if (wr_i.clr_wr)
      begin
         req_d = req_q & ~(wdata_i & ~clr_guard_q);
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         req_q <= BDI_REQ_RST;
      else
         req_q <= req_d;
   end

   // clear guard only ever drops bits; only reset brings them back
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         clr_guard_q <= BDI_GUARD_RST;
      else if (wr_i.cguard_wr)
         clr_guard_q <= clr_guard_q & ~wdata_i;
   end

   // set guard only ever gains bits
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         set_guard_q <= BDI_GUARD_RST;
      else if (wr_i.sguard_wr)
         set_guard_q <= set_guard_q | wdata_i;
   end

   assign req_o = req_q;
   assign clr_guard_o = clr_guard_q;
   assign set_guard_o = set_guard_q;

endmodule : bdi_side_bank

// File: hdl/bdi_doorbell.sv
// bdi_doorbell: software doorbell interrupts of a bus bridge, one request array per side.
// assumes a single-cycle strobe register port; read data are valid only the cycle after.
`timescale 1ns/1ps

// Function
// - writing ones to the upper half at 0x70 clears secondary requests, reset value zero.
// - reading the upper half at 0x70 returns the live secondary request bits.
// - writing ones to the lower half at 0x74 sets primary requests; reads show them.
// - writing ones to the upper half at 0x74 sets secondary requests; reads show them.
// - the primary clear guard at 0x78 low resets to ones and a written one zeroes a bit.
// - a primary clear guard bit of one blocks clearing that primary request.
// - the secondary clear guard at 0x78 high resets to ones, drops on a one, blocks clears.
// - the primary set guard at 0x7c low resets to ones, gains on a one, blocks sets.
// - the secondary set guard at 0x7c high resets to ones, gains on a one, blocks sets.
// - writing ones to the lower half at 0x70 clears primary requests; reads show them.
module bdi_doorbell
   import bdi_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire bdi_pkg::bdi_bus_req_t bus_i,
   output logic [31:0] rdata_o,
   output logic pri_irq_o,
   output logic sec_irq_o
);

   import bdi_pkg::*;

   logic hit_clr;
   logic hit_set;
   logic hit_cguard;
   logic hit_sguard;
   logic hit_any;
   bdi_bank_wr_t bank_wr;
   logic [1:0][15:0] req_w;
   logic [1:0][15:0] clr_guard_w;
   logic [1:0][15:0] set_guard_w;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;

   // full byte-address compare, so unaligned addresses fall through as unmapped
   assign hit_clr = (bus_i.addr == BDI_OFS_REQ_CLEAR);
   assign hit_set = (bus_i.addr == BDI_OFS_REQ_SET);
   assign hit_cguard = (bus_i.addr == BDI_OFS_CLEAR_GUARD);
   assign hit_sguard = (bus_i.addr == BDI_OFS_SET_GUARD);
   assign hit_any = hit_clr | hit_set | hit_cguard | hit_sguard;

   always_comb
   begin
      bank_wr.clr_wr = bus_i.wr & hit_clr;
      bank_wr.set_wr = bus_i.wr & hit_set;
      bank_wr.cguard_wr = bus_i.wr & hit_cguard;
      bank_wr.sguard_wr = bus_i.wr & hit_sguard;
   end

   // both sides share the strobes; each bank takes its own half of the write data
   for (genvar g = 0; g < BDI_SIDES; g++)
   begin : g_side
      bdi_side_bank u_bank (
         .sys_clk_i(sys_clk_i),
         .rst_i(rst_i),
         .wr_i(bank_wr),
         .wdata_i(bus_i.wdata[g*BDI_HALF_W +: BDI_HALF_W]),
         .req_o(req_w[g]),
         .clr_guard_o(clr_guard_w[g]),
         .set_guard_o(set_guard_w[g])
      );
   end

   // 0x70 and 0x74 are two views of the same request array
   always_comb
   begin
      rdata_d = BDI_RDATA_IDLE;
      case (1'b1)
         hit_clr, hit_set:
         begin
            rdata_d = {req_w[BDI_SIDE_SEC], req_w[BDI_SIDE_PRI]};
         end
         hit_cguard:
         begin
            rdata_d = {clr_guard_w[BDI_SIDE_SEC], clr_guard_w[BDI_SIDE_PRI]};
         end
         hit_sguard:
         begin
            rdata_d = {set_guard_w[BDI_SIDE_SEC], set_guard_w[BDI_SIDE_PRI]};
         end
         default:
         begin
            rdata_d = BDI_RDATA_IDLE;
         end
      endcase
   end

   // read data stand one cycle only, zero otherwise, so a stale value is never mistaken
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         rdata_q <= BDI_RDATA_IDLE;
      else if (bus_i.rd)
         rdata_q <= rdata_d;
      else
         rdata_q <= BDI_RDATA_IDLE;
   end

   assign rdata_o = rdata_q;

   // level requests straight from the request flops, no extra latency
   assign pri_irq_o = |req_w[BDI_SIDE_PRI];
   assign sec_irq_o = |req_w[BDI_SIDE_SEC];

   default clocking cb @(posedge sys_clk_i);
   endclocking

   default disable iff (rst_i);

   logic [15:0] pri_req;
   logic [15:0] sec_req;
   logic [15:0] pri_cg;
   logic [15:0] sec_cg;
   logic [15:0] pri_sg;
   logic [15:0] sec_sg;
   logic [15:0] wd_pri;
   logic [15:0] wd_sec;

   assign pri_req = req_w[BDI_SIDE_PRI];
   assign sec_req = req_w[BDI_SIDE_SEC];
   assign pri_cg = clr_guard_w[BDI_SIDE_PRI];
   assign sec_cg = clr_guard_w[BDI_SIDE_SEC];
   assign pri_sg = set_guard_w[BDI_SIDE_PRI];
   assign sec_sg = set_guard_w[BDI_SIDE_SEC];
   assign wd_pri = bus_i.wdata[BDI_PRI_LSB +: BDI_HALF_W];
   assign wd_sec = bus_i.wdata[BDI_SEC_LSB +: BDI_HALF_W];

   sequence s_clr_wr;
      bus_i.wr && (bus_i.addr == BDI_OFS_REQ_CLEAR);
   endsequence

   sequence s_set_wr;
      bus_i.wr && (bus_i.addr == BDI_OFS_REQ_SET);
   endsequence

   // reset is checked without the default disable, since it is the cause
   AST_RESET_STATE: assert property (disable iff (1'b0)
      rst_i |=> (pri_req == BDI_REQ_RST) && (sec_req == BDI_REQ_RST)
         && (pri_cg == BDI_GUARD_RST) && (sec_cg == BDI_GUARD_RST)
         && (pri_sg == BDI_GUARD_RST) && (sec_sg == BDI_GUARD_RST)
         && (rdata_o == BDI_RDATA_IDLE))
      else $error("state not at reset values after reset");

   AST_SEC_CLEAR: assert property (
      s_clr_wr |=> sec_req == ($past(sec_req) & ~($past(wd_sec) & ~$past(sec_cg))))
      else $error("secondary clear write did not clear unguarded bits");

   AST_READ_LIVE: assert property (
      bus_i.rd && (bus_i.addr == BDI_OFS_REQ_CLEAR)
      |=> (rdata_o[31:16] == $past(sec_req)) && (rdata_o[15:0] == $past(pri_req))
      ##1 (rdata_o == BDI_RDATA_IDLE) || $past(bus_i.rd))
      else $error("request read did not return live bits for one cycle");

   AST_PRI_SET: assert property (
      s_set_wr |=> pri_req == ($past(pri_req) | ($past(wd_pri) & ~$past(pri_sg))))
      else $error("primary set write did not set unguarded bits");

   AST_SEC_SET: assert property (
      s_set_wr |=> sec_req == ($past(sec_req) | ($past(wd_sec) & ~$past(sec_sg))))
      else $error("secondary set write did not set unguarded bits");

   AST_PRI_CGUARD: assert property (
      bus_i.wr && (bus_i.addr == BDI_OFS_CLEAR_GUARD)
      |=> (pri_cg == ($past(pri_cg) & ~$past(wd_pri))) && $stable(pri_req))
      else $error("primary clear guard write wrong");

   AST_PRI_CLR_BLOCKED: assert property (
      s_clr_wr |=> (($past(pri_req) & $past(pri_cg)) & ~pri_req) == 16'h0000)
      else $error("guarded primary request was cleared");

   AST_SEC_CGUARD: assert property (
      bus_i.wr && (bus_i.addr == BDI_OFS_CLEAR_GUARD)
      |=> (sec_cg == ($past(sec_cg) & ~$past(wd_sec))) && $stable(sec_req))
      else $error("secondary clear guard write wrong");

   AST_PRI_SGUARD: assert property (
      bus_i.wr && (bus_i.addr == BDI_OFS_SET_GUARD)
      |=> (pri_sg == ($past(pri_sg) | $past(wd_pri))) && $stable(pri_req))
      else $error("primary set guard write wrong");

   AST_SEC_SGUARD: assert property (
      bus_i.wr && (bus_i.addr == BDI_OFS_SET_GUARD)
      |=> (sec_sg == ($past(sec_sg) | $past(wd_sec))) && $stable(sec_req))
      else $error("secondary set guard write wrong");

   AST_GUARDED_SET: assert property (
      s_set_wr |=> ((~$past(pri_req) & $past(pri_sg)) & pri_req) == 16'h0000)
      else $error("guarded primary request was set");

   AST_PRI_CLEAR: assert property (
      s_clr_wr |=> pri_req == ($past(pri_req) & ~($past(wd_pri) & ~$past(pri_cg))))
      else $error("primary clear write did not clear unguarded bits");

   AST_IRQ_LEVEL: assert property (
      (pri_irq_o == (pri_req != 16'h0000)) && (sec_irq_o == (sec_req != 16'h0000)))
      else $error("interrupt output does not follow request array");

   AST_ZERO_WRITE: assert property (
      bus_i.wr && (bus_i.wdata == 32'h0000_0000)
      |=> $stable(req_w) && $stable(clr_guard_w) && $stable(set_guard_w))
      else $error("write of zero changed state");

   AST_IDLE_HOLD: assert property (
      !bus_i.wr [*2] |=> $stable(req_w))
      else $error("request bits moved without a write");

   AST_SEC_CLR_BLOCKED: assert property (
      s_clr_wr |=> (($past(sec_req) & $past(sec_cg)) & ~sec_req) == 16'h0000)
      else $error("guarded secondary request was cleared");

   AST_SEC_GUARDED_SET: assert property (
      s_set_wr |=> ((~$past(sec_req) & $past(sec_sg)) & sec_req) == 16'h0000)
      else $error("guarded secondary request was set");

   // every readable word returns the state as it stood at the read edge
   AST_READ_SET_VIEW: assert property (
      bus_i.rd && hit_set
      |=> rdata_o == {$past(sec_req), $past(pri_req)})
      else $error("set view read did not return the request bits");

   AST_READ_CGUARD: assert property (
      bus_i.rd && hit_cguard
      |=> rdata_o == {$past(sec_cg), $past(pri_cg)})
      else $error("clear guard read wrong");

   AST_READ_SGUARD: assert property (
      bus_i.rd && hit_sguard
      |=> rdata_o == {$past(sec_sg), $past(pri_sg)})
      else $error("set guard read wrong");

   AST_READ_UNMAPPED: assert property (
      bus_i.rd && !hit_any
      |=> rdata_o == BDI_RDATA_IDLE)
      else $error("unmapped read returned data");

   // read data must not linger, or software would take a stale word for an answer
   AST_RDATA_IDLE: assert property (
      !bus_i.rd |=> rdata_o == BDI_RDATA_IDLE)
      else $error("read data stood without a read");

   // only reset may raise a clear guard bit again or lower a set guard bit
   AST_PRI_CG_NO_RISE: assert property (
      (~$past(pri_cg) & pri_cg) == 16'h0000)
      else $error("primary clear guard bit rose without reset");

   AST_SEC_CG_NO_RISE: assert property (
      (~$past(sec_cg) & sec_cg) == 16'h0000)
      else $error("secondary clear guard bit rose without reset");

   AST_PRI_SG_NO_FALL: assert property (
      ($past(pri_sg) & ~pri_sg) == 16'h0000)
      else $error("primary set guard bit fell without reset");

   AST_SEC_SG_NO_FALL: assert property (
      ($past(sec_sg) & ~sec_sg) == 16'h0000)
      else $error("secondary set guard bit fell without reset");

   // nothing but a decoded write may move state
   AST_PRI_REQ_NEEDS_WR: assert property (
      !$stable(pri_req) |-> $past(bank_wr.clr_wr) || $past(bank_wr.set_wr))
      else $error("primary request moved without a request write");

   AST_SEC_REQ_NEEDS_WR: assert property (
      !$stable(sec_req) |-> $past(bank_wr.clr_wr) || $past(bank_wr.set_wr))
      else $error("secondary request moved without a request write");

   AST_CG_NEEDS_WR: assert property (
      !$stable(clr_guard_w) |-> $past(bank_wr.cguard_wr))
      else $error("clear guard moved without a guard write");

   AST_SG_NEEDS_WR: assert property (
      !$stable(set_guard_w) |-> $past(bank_wr.sguard_wr))
      else $error("set guard moved without a guard write");

   AST_UNMAPPED_WRITE: assert property (
      bus_i.wr && !hit_any
      |=> $stable(req_w) && $stable(clr_guard_w) && $stable(set_guard_w))
      else $error("unmapped write changed state");

   AST_CLR_KEEPS_GUARDS: assert property (
      s_clr_wr |=> $stable(clr_guard_w) && $stable(set_guard_w))
      else $error("request clear write moved a guard");

   AST_SET_KEEPS_GUARDS: assert property (
      s_set_wr |=> $stable(clr_guard_w) && $stable(set_guard_w))
      else $error("request set write moved a guard");

   AST_CG_WR_KEEPS_SG: assert property (
      bank_wr.cguard_wr |=> $stable(set_guard_w))
      else $error("clear guard write moved a set guard");

   AST_SG_WR_KEEPS_CG: assert property (
      bank_wr.sguard_wr |=> $stable(clr_guard_w))
      else $error("set guard write moved a clear guard");

   AST_IRQ_RESET: assert property (disable iff (1'b0)
      rst_i |=> !pri_irq_o && !sec_irq_o)
      else $error("interrupt raised after reset");

   COV_PRI_RAISE: cover property (
      bus_i.wr && (bus_i.addr == BDI_OFS_SET_GUARD) ##1
      bus_i.wr && (bus_i.addr == BDI_OFS_CLEAR_GUARD) ##[1:20] $rose(pri_irq_o));

   COV_SEC_CLEAR: cover property (
      sec_irq_o ##1 s_clr_wr ##1 !sec_irq_o);

   COV_READ_BACK: cover property (
      bus_i.rd && (bus_i.addr == BDI_OFS_REQ_SET) ##1 (rdata_o != BDI_RDATA_IDLE));

   COV_CLR_DROPS_GUARD: cover property (
      bus_i.wr && (bus_i.addr == BDI_OFS_CLEAR_GUARD) ##1 (pri_cg != BDI_GUARD_RST));

   COV_UNMAPPED_READ: cover property (
      bus_i.rd && !hit_any ##1 (rdata_o == BDI_RDATA_IDLE));

endmodule : bdi_doorbell

// File: testbench/bdi_host_model.sv
// bdi_host_model: register-port master standing for the software on either bridge bus.
// assumes the bdi_doorbell register port; every change lands just after a rising edge.
`timescale 1ns/1ps

module bdi_host_model
   import bdi_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic [31:0] rdata_i,
   output bdi_pkg::bdi_bus_req_t bus_o
);
   initial
   begin
      bus_o = '0;
   end

   // released address and data show the inverse, so a stale value is never mistaken for a fresh one
   task automatic wr_word(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      bus_o.addr <= a;
      bus_o.wdata <= d;
      bus_o.wr <= 1'b1;
      @(posedge sys_clk_i);
      bus_o.wr <= 1'b0;
      bus_o.addr <= ~a;
      bus_o.wdata <= ~d;
   endtask : wr_word

   task automatic rd_word(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      bus_o.addr <= a;
      bus_o.rd <= 1'b1;
      @(posedge sys_clk_i);
      bus_o.rd <= 1'b0;
      bus_o.addr <= ~a;
      #1;
      d = rdata_i;
   endtask : rd_word
endmodule : bdi_host_model

// File: testbench/bridge_doorbell_irq_set_clear_tb.sv
// bridge_doorbell_irq_set_clear_tb: self-checking bench of the doorbell register block.
// assumes bdi_doorbell and bdi_host_model; one 20 MHz clock, synchronous reset.
`timescale 1ns/1ps

module bridge_doorbell_irq_set_clear_tb;
   import bdi_pkg::*;
   logic sys_clk_i;
   logic rst_i;
   bdi_pkg::bdi_bus_req_t bus;
   logic [31:0] rdata_o;
   logic pri_irq_o;
   logic sec_irq_o;
   logic [31:0] rd;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;

   bdi_doorbell dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata_o),
      .pri_irq_o(pri_irq_o), .sec_irq_o(sec_irq_o));
   bdi_host_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdata_o), .bus_o(bus));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   // the whole run needs well under a hundred cycles
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         $display("Error at %0t: run did not complete", $time);
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      host.rd_word(a, rd);
      chk(rd, exp, what);
   endtask : rd_chk

   // mid-cycle, so a request flop launched by the last write has settled
   task automatic irq_chk(input logic [1:0] exp);
      @(negedge sys_clk_i);
      chk(32'({pri_irq_o, sec_irq_o}), 32'(exp), "irq lines");
   endtask : irq_chk

   task automatic t_reset_values();
      rd_chk(BDI_OFS_REQ_CLEAR, 32'h0000_0000, "request clear view");
      rd_chk(BDI_OFS_REQ_SET, 32'h0000_0000, "request set view");
      rd_chk(BDI_OFS_CLEAR_GUARD, 32'hffff_ffff, "clear guards");
      rd_chk(BDI_OFS_SET_GUARD, 32'hffff_ffff, "set guards");
      irq_chk(2'b00);
   endtask : t_reset_values

   // set guards start at ones and can only gain ones, so every set is refused
   task automatic t_set_blocked();
      host.wr_word(BDI_OFS_REQ_SET, 32'hffff_ffff);
      irq_chk(2'b00);
      rd_chk(BDI_OFS_REQ_SET, 32'h0000_0000, "guarded set");
      host.wr_word(BDI_OFS_SET_GUARD, 32'h0000_0000);
      rd_chk(BDI_OFS_SET_GUARD, 32'hffff_ffff, "zero write to set guards");
   endtask : t_set_blocked

   task automatic t_clear_guard();
      host.wr_word(BDI_OFS_CLEAR_GUARD, 32'h0001_8000);
      rd_chk(BDI_OFS_CLEAR_GUARD, 32'hfffe_7fff, "edge guard bits");
      @(posedge sys_clk_i);
      #1;
      chk(rdata_o, 32'h0000_0000, "read data after its cycle");
      host.wr_word(BDI_OFS_CLEAR_GUARD, 32'h0000_0000);
      rd_chk(BDI_OFS_CLEAR_GUARD, 32'hfffe_7fff, "zero write to clear guards");
      host.wr_word(BDI_OFS_CLEAR_GUARD, 32'hffff_ffff);
      rd_chk(BDI_OFS_CLEAR_GUARD, 32'h0000_0000, "all clear guards dropped");
      host.wr_word(BDI_OFS_REQ_CLEAR, 32'hffff_ffff);
      rd_chk(BDI_OFS_REQ_CLEAR, 32'h0000_0000, "clear with guards open");
      irq_chk(2'b00);
   endtask : t_clear_guard

   task automatic t_reset_again();
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd_chk(BDI_OFS_CLEAR_GUARD, 32'hffff_ffff, "guards after second reset");
      host.wr_word(8'h79, 32'hffff_ffff);
      host.wr_word(8'h90, 32'hffff_ffff);
      rd_chk(BDI_OFS_CLEAR_GUARD, 32'hffff_ffff, "unaligned write ignored");
      rd_chk(8'h79, 32'h0000_0000, "unaligned read");
      rd_chk(8'h90, 32'h0000_0000, "unmapped read");
   endtask : t_reset_again

   initial
   begin
      rst_i = 1'b1;
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_reset_values();
      t_set_blocked();
      t_clear_guard();
      t_reset_again();
      tally_and_finish();
   end
endmodule : bridge_doorbell_irq_set_clear_tb
